// ===== bsc_defines.vh
// Constants shared by the backup switch controller files
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses) and fields
// ----------------------------------------------------------------
`define BSC_REG_CTRL      4'h0
`define BSC_REG_CHAN      4'h4
`define BSC_REG_STAT      4'h8
`define BSC_REG_LINK      4'hC
`define BSC_CTRL_HOLD     0
`define BSC_CTRL_RESTORE  1
`define BSC_RST_HOLD      1'b0
`define BSC_RST_ADDR      5'h00
`define BSC_RST_RIF       2'h0
// ----------------------------------------------------------------
// Channel modes, interfaces, menu pages, display phases
// ----------------------------------------------------------------
`define BSC_MODE_AUTO     2'h0
`define BSC_MODE_MANUAL   2'h1
`define BSC_MODE_REMOTE   2'h2
`define BSC_RIF_MULTIDROP 2'h2
`define BSC_RIF_LAST      2'h2
`define BSC_PAGE_NORMAL   4'h0
`define BSC_PAGE_FIRST    4'h1
`define BSC_PAGE_IF       4'h9
`define BSC_PAGE_ADDR     4'hA
`define BSC_PAGE_HOLD     4'hB
`define BSC_PAGE_RESTORE  4'hC
`define BSC_PAGE_SAVE     4'hD
`define BSC_PH_ALLSEG     2'h0
`define BSC_PH_VERSION    2'h1
`define BSC_PH_STATUS     2'h2
// ----------------------------------------------------------------
// Frame characters
// ----------------------------------------------------------------
`define BSC_CHR_OPEN      8'h7B
`define BSC_CHR_CLOSE     8'h7D
`define BSC_CHR_CMD       8'h43
`define BSC_CHR_STAT      8'h53
`define BSC_CHR_ACK       8'h3E
`define BSC_CHR_ZERO      8'h30
`define BSC_CHR_ONE       8'h31
`define BSC_CHR_FIVE      8'h35
`define BSC_CHR_SIX       8'h36
`define BSC_ADDR_MAX      7'h1F
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BSC_CLK_KHZ       50000
`define BSC_SHOW_MS       1000
`define BSC_SHOW_CYC      (`BSC_SHOW_MS * `BSC_CLK_KHZ)
`endif

// ===== bsc_frame_parser.v
// Serial command frame parser for the backup switch controller
`timescale 1ns/1ns
`default_nettype none
`include "bsc_defines.vh"
module bsc_frame_parser (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire [7:0] rx_byte,
    input  wire       rx_valid,
    input  wire       addr_mode,
    input  wire [4:0] my_addr,
    output reg        cmd_valid_ff,
    output reg        cmd_status_ff,
    output reg  [7:0] cmd_code_ff,
    output reg  [7:0] cmd_arg0_ff,
    output reg  [7:0] cmd_arg1_ff,
    output reg  [1:0] cmd_nargs_ff
);
    localparam S_IDLE = 3'h0;
    localparam S_AHI  = 3'h1;
    localparam S_ALO  = 3'h2;
    localparam S_TYPE = 3'h3;
    localparam S_CODE = 3'h4;
    localparam S_DATA = 3'h5;

    reg  [2:0] state_ff;
    reg  [3:0] hi_ff;
    reg        match_ff;
    wire       is_digit;
    wire [6:0] addr_val;

    assign is_digit = (rx_byte[7:4] == 4'h3) && (rx_byte[3:0] <= 4'h9);
    assign addr_val = {3'h0, hi_ff} * 7'h0A + {3'h0, rx_byte[3:0]};

    always @(posedge clk) begin
        if (rst) begin
            state_ff      <= S_IDLE;
            hi_ff         <= 4'h0;
            match_ff      <= 1'b0;
            cmd_valid_ff  <= 1'b0;
            cmd_status_ff <= 1'b0;
            cmd_code_ff   <= 8'h00;
            cmd_arg0_ff   <= 8'h00;
            cmd_arg1_ff   <= 8'h00;
            cmd_nargs_ff  <= 2'h0;
        end else if (ce) begin
            cmd_valid_ff <= 1'b0;
            if (rx_valid) begin
                // An opening brace always restarts, even mid frame
                if (rx_byte == `BSC_CHR_OPEN) begin
                    state_ff <= addr_mode ? S_AHI : S_TYPE;
                    match_ff <= ~addr_mode;
                end else begin
                    case (state_ff)
                    S_AHI: begin
                        hi_ff    <= rx_byte[3:0];
                        state_ff <= is_digit ? S_ALO : S_IDLE;
                    end
                    S_ALO: begin
                        match_ff <= is_digit && (addr_val <= `BSC_ADDR_MAX)
                                    && (addr_val == {2'h0, my_addr});
                        state_ff <= is_digit ? S_TYPE : S_IDLE;
                    end
                    S_TYPE: begin
                        cmd_status_ff <= (rx_byte == `BSC_CHR_STAT);
                        if ((rx_byte == `BSC_CHR_CMD) ||
                            (rx_byte == `BSC_CHR_STAT)) begin
                            state_ff <= S_CODE;
                        end else begin
                            state_ff <= S_IDLE;
                        end
                    end
                    S_CODE: begin
                        cmd_code_ff  <= rx_byte;
                        cmd_nargs_ff <= 2'h0;
                        state_ff     <= S_DATA;
                    end
                    S_DATA: begin
                        if (rx_byte == `BSC_CHR_CLOSE) begin
                            cmd_valid_ff <= match_ff;
                            state_ff     <= S_IDLE;
                        end else if (cmd_nargs_ff == 2'h0) begin
                            cmd_arg0_ff  <= rx_byte;
                            cmd_nargs_ff <= 2'h1;
                        end else if (cmd_nargs_ff == 2'h1) begin
                            cmd_arg1_ff  <= rx_byte;
                            cmd_nargs_ff <= 2'h2;
                        end else begin
                            // No known command carries more data
                            state_ff <= S_IDLE;
                        end
                    end
                    default: state_ff <= S_IDLE;
                    endcase
                end
            end
        end
    end
endmodule // bsc_frame_parser
`default_nettype wire

// ===== bsc_host.sv
// Host model: sends command frames, collects answer bytes
`timescale 1ns/1ns
`default_nettype none
module bsc_host (
    input wire logic        clk,
    input wire logic        tx_valid_ff,
    input wire logic [7:0]  tx_byte_ff,
    output var logic [7:0]  rx_byte,
    output var logic        rx_valid,
    output var logic        tx_ready,
    output var logic [39:0] got
);
    logic slow = 1'b0;
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
        got = 40'h0;
    end
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid_ff && tx_ready)
            got <= {got[31:0], tx_byte_ff};
    end
    task clr; got = 40'h0; endtask
    // Address prefix, if any, is in the text
    task send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk);
            rx_byte <= s[i];
            rx_valid <= 1'b1;
            @(posedge clk);
            rx_valid <= 1'b0;
            rx_byte <= ~s[i];
        end
    endtask
endmodule // bsc_host
`default_nettype wire

// ===== bsc_props.sv
// Port checker for the backup switch controller
`timescale 1ns/1ns
`default_nettype none
module bsc_props (
    input wire logic       clk, rst, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic       held_mark_ff, tx_valid_ff, tx_ready, nv_wr_ff,
    input wire logic [4:0] lock_pin, alarm_led_ff,
    input wire logic [2:0] bu_sel_ff,
    input wire logic [1:0] disp_phase_ff,
    input wire logic [3:0] menu_page_ff,
    input wire logic [7:0] tx_byte_ff,
    input wire logic [11:0] nv_data_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_alarm_lock: assert property ($stable(lock_pin) [*4] |->
        alarm_led_ff == ~lock_pin) else $error("alarm led wrong");
    a_held_backup: assert property (held_mark_ff |->
        bu_sel_ff != 3'h0) else $error("held mark without backup");
    a_sel_range: assert property (bu_sel_ff <= 3'h4)
        else $error("backup select out of range");
    a_phase_order: assert property ($changed(disp_phase_ff) |->
        disp_phase_ff == $past(disp_phase_ff) + 2'h1)
        else $error("display phase out of order");
    a_page_range: assert property (menu_page_ff <= 4'hD)
        else $error("menu page out of range");
    a_save_entry: assert property ($changed(menu_page_ff) &&
        menu_page_ff == 4'hD |-> $past(menu_page_ff) inside
        {4'h1, 4'hB, 4'hC}) else $error("bad entry to save prompt");
    a_tx_hold: assert property (tx_valid_ff && !tx_ready |=>
        tx_valid_ff && $stable(tx_byte_ff)) else $error("tx dropped");
    a_nv_write: assert property (nv_wr_ff |-> $changed(nv_data_ff))
        else $error("store write without new data");
endmodule // bsc_props
`default_nettype wire

// ===== bsc_top.v
// Backup switch controller: selection, hold mode, menu, link, registers
// Summary of operation
// - Per channel: manual beats remote beats automatic
// - Twelve ordered menu pages after normal display
// - Edits apply only via menu key and save
// - Save prompt on return or past last page
// - Channel protection and mode kept non-volatile
// - Power-up: all segments, version, then status
// - Horizontal moves cursor, vertical changes value
// - Loss of lock flags that unit alarmed
// - Hold set command: 1 enables, 0 disables
// - Hold query answers frame with one digit
// - Hold on: stay in backup after alarm clears
// - Held marker shown in backup mode column
// - Restore command or panel restore releases hold
// - Restore page follows hold page only when on
// - Hold off: return when causing alarm clears
// - One front-panel indicator per alarmed unit
// - Frames: brace, address, letter, code, data, brace
// - Address prefix only multidrop, range 00-31
// - Executed command acknowledged with greater-than
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "bsc_defines.vh"
module bsc_top #(
    parameter SHOW_CYC = `BSC_SHOW_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [4:0]  key_pin,
    input  wire [4:0]  lock_pin,
    input  wire [11:0] nv_rd_data,
    output reg         nv_wr_ff,
    output reg  [11:0] nv_data_ff,
    input  wire [7:0]  rx_byte,
    input  wire        rx_valid,
    input  wire        tx_ready,
    output reg         tx_valid_ff,
    output reg  [7:0]  tx_byte_ff,
    output reg  [2:0]  bu_sel_ff,
    output reg         held_mark_ff,
    output reg  [4:0]  alarm_led_ff,
    output reg  [1:0]  disp_phase_ff,
    output reg  [3:0]  menu_page_ff,
    output reg         save_yes_ff
);
    // Key bits: 4 menu/execute, 3 left, 2 right, 1 up, 0 down
    reg  [4:0]  key_s1_ff, key_s2_ff, key_s3_ff;
    reg  [4:0]  lock_s1_ff, lock_s2_ff;
    reg  [3:0]  prot_ff, p_prot_ff;
    reg  [7:0]  mode_ff, p_mode_ff;
    reg         hold_ff, p_hold_ff, p_restore_ff, restore_ff;
    reg  [1:0]  rif_ff, p_rif_ff;
    reg  [4:0]  addr_ff, p_addr_ff;
    reg  [3:0]  held_ff;
    reg         boot_ff;
    reg  [25:0] show_cnt_ff;
    reg  [7:0]  txq_ff [0:4];
    reg  [2:0]  tx_idx_ff, tx_len_ff;
    reg  [2:0]  nxt_sel;
    reg  [1:0]  best;
    reg  [1:0]  ch, m, mv;
    integer     k;
    wire [4:0]  kp;
    wire [4:0]  alarm;
    wire [3:0]  nxt_held;
    wire [7:0]  rank;
    wire        cmd_valid, cmd_status;
    wire [7:0]  cmd_code, cmd_arg0, cmd_arg1;
    wire [1:0]  cmd_nargs;
    wire        wb_req, wb_wr;
    wire        up, dn;
    wire        cmd_ch, cmd_hold, cmd_rest, cmd_query, cmd_done;
    wire [1:0]  cidx;

    assign kp     = key_s2_ff & ~key_s3_ff;
    assign up     = kp[1];
    assign dn     = kp[0];
    assign alarm  = ~lock_s2_ff;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            key_s1_ff  <= 5'h00;
            key_s2_ff  <= 5'h00;
            key_s3_ff  <= 5'h00;
            lock_s1_ff <= 5'h1F;
            lock_s2_ff <= 5'h1F;
        end else if (ce) begin
            key_s1_ff  <= key_pin;
            key_s2_ff  <= key_s1_ff;
            key_s3_ff  <= key_s2_ff;
            lock_s1_ff <= lock_pin;
            lock_s2_ff <= lock_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // Serial command link
    // ----------------------------------------------------------------
    bsc_frame_parser u_parser (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .rx_byte       (rx_byte),
        .rx_valid      (rx_valid),
        .addr_mode     (rif_ff == `BSC_RIF_MULTIDROP),
        .my_addr       (addr_ff),
        .cmd_valid_ff  (cmd_valid),
        .cmd_status_ff (cmd_status),
        .cmd_code_ff   (cmd_code),
        .cmd_arg0_ff   (cmd_arg0),
        .cmd_arg1_ff   (cmd_arg1),
        .cmd_nargs_ff  (cmd_nargs)
    );

    assign cidx     = cmd_code[1:0] - 2'h1;
    assign cmd_ch   = cmd_valid & ~cmd_status & (cmd_nargs == 2'h2) &
                      (cmd_code >= `BSC_CHR_ONE) & (cmd_code < `BSC_CHR_FIVE);
    assign cmd_hold = cmd_valid & ~cmd_status & (cmd_nargs == 2'h1) &
                      (cmd_code == `BSC_CHR_FIVE) &
                      (cmd_arg0[7:1] == `BSC_CHR_ZERO >> 1);
    assign cmd_rest = cmd_valid & ~cmd_status & (cmd_nargs == 2'h1) &
                      (cmd_code == `BSC_CHR_SIX);
    assign cmd_query = cmd_valid & cmd_status & (cmd_nargs == 2'h0) &
                       (cmd_code == `BSC_CHR_FIVE);
    assign cmd_done = cmd_ch | cmd_hold | cmd_rest;

    // Answers are dropped while a previous one is still going out
    always @(posedge clk) begin
        if (rst) begin
            tx_valid_ff <= 1'b0;
            tx_byte_ff  <= 8'h00;
            tx_idx_ff   <= 3'h0;
            tx_len_ff   <= 3'h0;
        end else if (ce) begin
            if (tx_valid_ff) begin
                if (tx_ready) begin
                    if (tx_idx_ff < tx_len_ff) begin
                        tx_byte_ff <= txq_ff[tx_idx_ff];
                        tx_idx_ff  <= tx_idx_ff + 3'h1;
                    end else begin
                        tx_valid_ff <= 1'b0;
                    end
                end
            end else if (cmd_done) begin
                tx_valid_ff <= 1'b1;
                tx_byte_ff  <= `BSC_CHR_ACK;
                tx_len_ff   <= 3'h0;
            end else if (cmd_query) begin
                tx_valid_ff <= 1'b1;
                tx_byte_ff  <= `BSC_CHR_OPEN;
                txq_ff[0]   <= `BSC_CHR_OPEN;
                txq_ff[1]   <= `BSC_CHR_STAT;
                txq_ff[2]   <= `BSC_CHR_FIVE;
                txq_ff[3]   <= `BSC_CHR_ZERO | {7'h00, hold_ff};
                txq_ff[4]   <= `BSC_CHR_CLOSE;
                tx_idx_ff   <= 3'h1;
                tx_len_ff   <= 3'h5;
            end
        end
    end

    // ----------------------------------------------------------------
    // Source resolution and hold per channel
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            wire auto_ch = prot_ff[gi] &
                           (mode_ff[2*gi+1:2*gi] == `BSC_MODE_AUTO);
            // Set after clear so a new alarm outlives a restore
            assign nxt_held[gi] = (hold_ff & auto_ch & alarm[gi]) |
                (held_ff[gi] & hold_ff & ~restore_ff);
            assign rank[2*gi+1:2*gi] =
                ~prot_ff[gi] ? 2'h0 :
                (mode_ff[2*gi+1:2*gi] == `BSC_MODE_MANUAL) ? 2'h3 :
                (mode_ff[2*gi+1:2*gi] == `BSC_MODE_REMOTE) ? 2'h2 :
                (alarm[gi] | held_ff[gi]) ? 2'h1 : 2'h0;
        end
    endgenerate

    // Highest source wins; ties go to the lower channel
    always @* begin
        nxt_sel = 3'h0;
        best    = 2'h0;
        for (k = 3; k >= 0; k = k - 1) begin
            if ((rank[2*k +: 2] != 2'h0) && (rank[2*k +: 2] >= best)) begin
                best    = rank[2*k +: 2];
                nxt_sel = k[2:0] + 3'h1;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            held_ff      <= 4'h0;
            bu_sel_ff    <= 3'h0;
            held_mark_ff <= 1'b0;
            alarm_led_ff <= 5'h00;
        end else if (ce) begin
            held_ff      <= nxt_held;
            bu_sel_ff    <= nxt_sel;
            held_mark_ff <= (best == 2'h1) & |(held_ff & ~alarm[3:0]);
            alarm_led_ff <= alarm;
        end
    end

    // ----------------------------------------------------------------
    // Settings, menu and power-up display
    // ----------------------------------------------------------------
    always @* begin
        ch = menu_page_ff[2:1] - {1'b0, ~menu_page_ff[0]};
        m  = p_mode_ff[2*ch +: 2];
        mv = up ? ((m == `BSC_MODE_REMOTE) ? 2'h0 : m + 2'h1)
                : ((m == `BSC_MODE_AUTO) ? 2'h2 : m - 2'h1);
    end

    always @(posedge clk) begin
        if (rst) begin
            boot_ff       <= 1'b1;
            prot_ff       <= 4'h0;
            mode_ff       <= 8'h00;
            hold_ff       <= `BSC_RST_HOLD;
            rif_ff        <= `BSC_RST_RIF;
            addr_ff       <= `BSC_RST_ADDR;
            restore_ff    <= 1'b0;
            p_prot_ff     <= 4'h0;
            p_mode_ff     <= 8'h00;
            p_hold_ff     <= `BSC_RST_HOLD;
            p_rif_ff      <= `BSC_RST_RIF;
            p_addr_ff     <= `BSC_RST_ADDR;
            p_restore_ff  <= 1'b0;
            show_cnt_ff   <= 26'h0000000;
            disp_phase_ff <= `BSC_PH_ALLSEG;
            menu_page_ff  <= `BSC_PAGE_NORMAL;
            save_yes_ff   <= 1'b0;
            nv_wr_ff      <= 1'b0;
            nv_data_ff    <= 12'h000;
        end else if (ce) begin
            boot_ff    <= 1'b0;
            restore_ff <= 1'b0;
            // Stored inverted: a blank store means all protected
            if (boot_ff) begin
                prot_ff <= ~nv_rd_data[3:0];
                mode_ff <= nv_rd_data[11:4];
            end
            nv_data_ff <= {mode_ff, ~prot_ff};
            nv_wr_ff   <= ~boot_ff & ({mode_ff, ~prot_ff} != nv_data_ff);
            if (disp_phase_ff != `BSC_PH_STATUS) begin
                if (show_cnt_ff == SHOW_CYC - 1) begin
                    show_cnt_ff   <= 26'h0000000;
                    disp_phase_ff <= disp_phase_ff + 2'h1;
                end else begin
                    show_cnt_ff <= show_cnt_ff + 26'h0000001;
                end
            end
            if (cmd_ch) begin
                prot_ff[cidx] <= (cmd_arg0 == `BSC_CHR_ZERO);
                // Manual stays put against remote requests
                if (mode_ff[2*cidx +: 2] != `BSC_MODE_MANUAL) begin
                    mode_ff[2*cidx +: 2] <= (cmd_arg1 == `BSC_CHR_ONE) ?
                        `BSC_MODE_REMOTE : `BSC_MODE_AUTO;
                end
            end
            if (cmd_hold) begin
                hold_ff <= cmd_arg0[0];
            end
            if (cmd_rest && (cmd_arg0 == `BSC_CHR_ONE)) begin
                restore_ff <= 1'b1;
            end
            if (wb_wr && (wb_adr_i[3:2] == `BSC_REG_CTRL >> 2)) begin
                hold_ff <= wb_dat_i[`BSC_CTRL_HOLD];
                if (wb_dat_i[`BSC_CTRL_RESTORE]) begin
                    restore_ff <= 1'b1;
                end
            end
            if (wb_wr && (wb_adr_i[3:2] == `BSC_REG_LINK >> 2)) begin
                addr_ff <= wb_dat_i[4:0];
                if (wb_sel_i[1] && (wb_dat_i[9:8] <= `BSC_RIF_LAST)) begin
                    rif_ff <= wb_dat_i[9:8];
                end
            end
            if (disp_phase_ff == `BSC_PH_STATUS) begin
                if (menu_page_ff == `BSC_PAGE_NORMAL) begin
                    if (kp[4]) begin
                        menu_page_ff <= `BSC_PAGE_FIRST;
                        p_prot_ff    <= prot_ff;
                        p_mode_ff    <= mode_ff;
                        p_hold_ff    <= hold_ff;
                        p_rif_ff     <= rif_ff;
                        p_addr_ff    <= addr_ff;
                        p_restore_ff <= 1'b0;
                        save_yes_ff  <= 1'b0;
                    end
                end else if (menu_page_ff == `BSC_PAGE_SAVE) begin
                    if (up | dn) begin
                        save_yes_ff <= ~save_yes_ff;
                    end
                    if (kp[4]) begin
                        menu_page_ff <= `BSC_PAGE_NORMAL;
                        // Leaving without a confirmed save drops edits
                        if (save_yes_ff) begin
                            prot_ff    <= p_prot_ff;
                            mode_ff    <= p_mode_ff;
                            hold_ff    <= p_hold_ff;
                            rif_ff     <= p_rif_ff;
                            addr_ff    <= p_addr_ff;
                            restore_ff <= p_restore_ff & p_hold_ff;
                        end
                    end
                end else if (kp[4]) begin
                    menu_page_ff <= `BSC_PAGE_SAVE;
                end else if (kp[2]) begin
                    if ((menu_page_ff == `BSC_PAGE_RESTORE) ||
                        ((menu_page_ff == `BSC_PAGE_HOLD) && !p_hold_ff)) begin
                        menu_page_ff <= `BSC_PAGE_SAVE;
                    end else begin
                        menu_page_ff <= menu_page_ff + 4'h1;
                    end
                end else if (kp[3]) begin
                    // Stepping left off the first page is the return option
                    if (menu_page_ff == `BSC_PAGE_FIRST) begin
                        menu_page_ff <= `BSC_PAGE_SAVE;
                    end else begin
                        menu_page_ff <= menu_page_ff - 4'h1;
                    end
                end else if (up | dn) begin
                    case (menu_page_ff)
                    `BSC_PAGE_IF: begin
                        if (up) begin
                            p_rif_ff <= (p_rif_ff == `BSC_RIF_LAST) ? 2'h0
                                        : p_rif_ff + 2'h1;
                        end else begin
                            p_rif_ff <= (p_rif_ff == 2'h0) ? `BSC_RIF_LAST
                                        : p_rif_ff - 2'h1;
                        end
                    end
                    `BSC_PAGE_ADDR: p_addr_ff <= up ? p_addr_ff + 5'h01
                                                    : p_addr_ff - 5'h01;
                    `BSC_PAGE_HOLD: p_hold_ff <= ~p_hold_ff;
                    `BSC_PAGE_RESTORE: p_restore_ff <= up;
                    default: begin
                        if (menu_page_ff[0]) begin
                            p_prot_ff[ch] <= ~p_prot_ff[ch];
                        end else begin
                            p_mode_ff[2*ch +: 2] <= mv;
                        end
                    end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave: one wait state, only address bits 3:2 decoded, so every read hits a register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i[3:2])
                2'h0: wb_dat_o <= {31'h00000000, hold_ff};
                2'h1: wb_dat_o <= {16'h0000, mode_ff, 4'h0, prot_ff};
                2'h2: wb_dat_o <= {4'h0, menu_page_ff, 2'h0, disp_phase_ff,
                                   1'b0, bu_sel_ff, 4'h0, held_ff,
                                   3'h0, alarm_led_ff};
                2'h3: wb_dat_o <= {22'h000000, rif_ff, 3'h0, addr_ff};
                default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // bsc_top
`default_nettype wire

// ===== bsc_top_bench.sv
// Testbench for the backup switch controller
`timescale 1ns/1ns
`default_nettype none
module bsc_top_bench;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, menu_page_ff;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [4:0] key_pin = 5'h00, lock_pin = 5'h1F, alarm_led_ff;
    logic [11:0] nv_rd_data = 12'h082, nv_data_ff;
    logic [7:0] rx_byte, tx_byte_ff;
    logic [39:0] got;
    logic [2:0] bu_sel_ff;
    logic [1:0] disp_phase_ff;
    logic wb_ack_o, nv_wr_ff, rx_valid, tx_ready, tx_valid_ff;
    logic held_mark_ff, save_yes_ff;
    int mismatches = 0, checks_done = 0;
    wire wb_stb_i = wb_cyc_i;
    bsc_top #(.SHOW_CYC(4)) bsc_top_inst (.*);
    bsc_host bsc_host_inst (.*);
    initial forever #10 clk = ~clk;
    task chk(input logic [39:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        @(posedge clk);
    endtask
    task cmd(input string s, input logic [39:0] e);
        bsc_host_inst.clr();
        bsc_host_inst.send(s);
        repeat (30) @(posedge clk);
        chk(got, e);
    endtask
    task key(input int b);
        key_pin[b] <= 1'b1;
        repeat (4) @(posedge clk);
        key_pin[b] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task lock(input logic [4:0] v);
        lock_pin <= v;
        repeat (8) @(posedge clk);
    endtask
    task t_alarm;
        lock(5'h1E);
        chk(40'(bu_sel_ff), 40'h1);
        cmd("{C301}", 40'h3E);
        chk(40'(bu_sel_ff), 40'h3);
        cmd("{C300}", 40'h3E);
        lock(5'h1F);
        chk(40'(bu_sel_ff), 40'h0);
        cmd("{C51}", 40'h3E);
        bsc_host_inst.slow = 1'b1;
        cmd("{S5}", "{S51}");
        bsc_host_inst.slow = 1'b0;
        lock(5'h1B);
        lock(5'h1F);
        chk(40'({held_mark_ff, bu_sel_ff}), 40'hB);
        for (int n = 0; n < 2; n++) begin
            cmd("{C61}", 40'h3E);
            chk(40'(bu_sel_ff), 40'h0);
        end
        cmd("{C50}", 40'h3E);
        wb(1'b1, 4'hC, 32'h205);
        cmd("{06C50}", 40'h0);
        cmd("{05C50}", 40'h3E);
    endtask
    task t_menu;
        chk(40'(disp_phase_ff), 40'h2);
        for (int y = 0; y < 2; y++) begin
            key(4);
            key(2);
            chk(40'(menu_page_ff), 40'h2);
            key(3);
            key(0);
            key(3);
            chk(40'(menu_page_ff), 40'hD);
            if (y == 1)
                key(1);
            chk(40'(save_yes_ff), 40'(y));
            key(4);
            wb(1'b0, 4'h4, 32'h0);
            chk({8'h00, rd}, y ? 40'h80C : 40'h80D);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, 4'h4, 32'h0);
        chk({8'h00, rd}, 40'h80D);
        chk(40'(nv_data_ff), 40'h82);
        wb(1'b1, 4'h0, 32'h1);
        wb(1'b0, 4'h0, 32'h0);
        chk({8'h00, rd}, 40'h1);
        wb(1'b1, 4'h0, 32'h0);
        t_alarm;
        t_menu;
        results;
    end
    // A clean run needs under 1000 cycles
    initial begin
        #200000;
        mismatches++;
        results;
    end
endmodule // bsc_top_bench
bind bsc_top bsc_props bsc_props_inst (.*);
`default_nettype wire
